// [rtl/orw_remote.sv]
// Remote unit end: register read and write over the operations channel
// Behaviour
// RULE1: bit three zero means data, one opcode
// RULE2: bit four one odd byte, zero even
// RULE3: read opcode enters read mode, echoed
// RULE4: master then requests odd byte with opcode
// RULE5: echo request twice, data from third on
// RULE6: same data repeats while request repeats
// RULE7: each position toggle serves next byte
// RULE8: other confirmed message in read gives unable_to_comply
// RULE9: request past last byte answers end-of-data
// RULE10: master requests until all bytes or end-of-data
// RULE11: hold or return-to-normal ends read mode
// RULE12: write opcode enters write mode, echoed
// RULE13: master sends first byte as odd data
// RULE14: echo data, take byte on third copy
// RULE15: master toggles position per written byte
// RULE16: master closes write with end-of-data
// RULE17: commit only full count closed by end-of-data
// RULE18: bad count or close gives unable_to_comply
// RULE19: abort by hold/normal, else unable_to_comply
// RULE20: unable_to_comply reply replaces third and later echoes
// RULE21: leave unable_to_comply only on return-to-normal
// RULE22: return-to-normal clears latched conditions
// RULE23: opcodes carry a sixteen-register index
// RULE24: count identical consecutive frames, restart on change
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module orw_remote #(
	parameter int         REG_BYTES = 2,
	parameter logic [3:0] OWN_ADDR  = 4'h1 // Arbitrary unit address
) (
	input  wire logic                    SYS_CLK,
	input  wire logic                    SYS_RST,
	orw_link_if.remote                   LNK,
	output logic                         REG_WR,
	output logic [3:0]                   REG_WR_IDX,
	output logic [REG_BYTES*8-1:0]       REG_WR_DATA,
	output logic                         LATCH_CLR,
	output orw_pkg::orw_mode_e           MODE
);
	localparam int PW = $clog2(REG_BYTES + 2);
	localparam logic [PW-1:0] NBYTES = PW'(REG_BYTES);
	localparam logic [PW-1:0] OVER   = PW'(REG_BYTES + 1);

	orw_pkg::orw_frame_t     rx;
	orw_pkg::orw_frame_t     last_frm;
	orw_pkg::orw_frame_t     reply;
	logic [1:0]              same_cnt;
	logic [1:0]              next_cnt;
	logic                    same;
	logic                    held;
	logic                    confirm;
	logic [3:0]              cmd;
	logic [3:0]              sub;
	logic                    is_op;
	logic                    pos;
	logic                    is_rtn;
	logic                    is_hold;
	orw_pkg::orw_mode_e      next_mode;
	logic                    rd_step;
	logic                    wr_take;
	logic                    commit;
	logic                    opening;
	logic [REG_BYTES*8-1:0]  store [orw_pkg::REG_COUNT];
	logic [REG_BYTES*8-1:0]  rd_word;
	logic [7:0]              rd_byte;
	logic [3:0]              reg_idx;
	logic [PW-1:0]           rd_ptr;
	logic [PW-1:0]           next_ptr;
	logic                    rd_started;
	logic                    served_pos;
	logic [REG_BYTES*8-1:0]  wr_buf;
	logic [PW-1:0]           wr_cnt;
	logic                    wr_started;
	logic                    wr_pos;

	assign rx      = LNK.dn_frame;
	assign cmd     = rx[orw_pkg::CMD_LSB +: 4];
	assign sub     = rx[orw_pkg::SUB_LSB +: 4];               // [RULE23]
	assign is_op   = rx[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_OP; // [RULE1]
	assign pos     = rx[orw_pkg::POS_BIT];                     // [RULE2]
	assign is_rtn  = is_op && (cmd == orw_pkg::OP_RTN);
	assign is_hold = is_op && (cmd == orw_pkg::OP_HOLD);

	// Count saturates at three so that later copies keep the reply but
	// do not act a second time
	assign same     = (rx == last_frm) && (same_cnt != 2'h0);   // [RULE24]
	assign next_cnt = !same ? 2'h1 :
		(same_cnt == orw_pkg::CONFIRM_CNT) ? orw_pkg::CONFIRM_CNT :
		2'(same_cnt + 2'h1);
	assign held     = LNK.dn_valid && (next_cnt == orw_pkg::CONFIRM_CNT);
	assign confirm  = held && (same_cnt != orw_pkg::CONFIRM_CNT);

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			last_frm <= '0;
			same_cnt <= 2'h0;
		end else if (LNK.dn_valid) begin
			last_frm <= rx;
			same_cnt <= next_cnt;                               // [RULE24]
		end
	end

	always_comb begin
		next_mode = MODE;
		rd_step = 1'b0;
		wr_take = 1'b0;
		commit = 1'b0;
		if (confirm) begin
			unique case (MODE)
				orw_pkg::M_NORMAL: begin
					if (is_op && cmd == orw_pkg::OP_READ)
						next_mode = orw_pkg::M_READ;              // [RULE3]
					else if (is_op && cmd == orw_pkg::OP_WRITE)
						next_mode = orw_pkg::M_WRITE;             // [RULE12]
					else if (!(is_rtn || is_hold))
						next_mode = orw_pkg::M_UTC;
				end
				orw_pkg::M_READ: begin
					if (is_op && cmd == orw_pkg::OP_NEXT)
						rd_step = 1'b1;
					else if (is_rtn || is_hold)
						next_mode = orw_pkg::M_NORMAL;            // [RULE11]
					else
						next_mode = orw_pkg::M_UTC;               // [RULE8]
				end
				orw_pkg::M_WRITE: begin
					if (!is_op) begin
						wr_take = 1'b1;                           // [RULE14]
					end else if (cmd == orw_pkg::OP_EOD && wr_cnt == NBYTES) begin
						commit = 1'b1;                            // [RULE17]
						next_mode = orw_pkg::M_NORMAL;
					end else if (is_rtn || is_hold) begin
						next_mode = orw_pkg::M_NORMAL;            // [RULE19]
					end else begin
						next_mode = orw_pkg::M_UTC;               // [RULE18] [RULE19]
					end
				end
				orw_pkg::M_UTC: begin
					if (is_rtn)
						next_mode = orw_pkg::M_NORMAL;            // [RULE21]
				end
			endcase
		end
	end

	assign opening = confirm && (MODE == orw_pkg::M_NORMAL) &&
		(next_mode != orw_pkg::M_NORMAL) && (next_mode != orw_pkg::M_UTC);

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			MODE <= orw_pkg::M_NORMAL;
		else
			MODE <= next_mode;
	end

	// First request serves byte 0; a toggle steps on, a repeat of the
	// same position after a break serves the same byte again
	always_comb begin
		next_ptr = rd_ptr;
		if (rd_step) begin
			if (!rd_started)
				next_ptr = '0;
			else if (pos != served_pos && rd_ptr != NBYTES)
				next_ptr = PW'(rd_ptr + 1'b1);                 // [RULE7]
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			reg_idx <= 4'h0;
			rd_ptr <= '0;
			rd_started <= 1'b0;
			served_pos <= 1'b0;
		end else if (opening) begin
			reg_idx <= sub;                                     // [RULE23]
			rd_ptr <= '0;
			rd_started <= 1'b0;
		end else if (rd_step) begin
			rd_ptr <= next_ptr;
			rd_started <= 1'b1;
			served_pos <= pos;
		end
	end

	assign rd_word = store[reg_idx];
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < REG_BYTES; i++) begin
			if (next_ptr == PW'(i))
				rd_byte = rd_word[8*i +: 8];
		end
	end

	// Repeated copies of an already taken byte are ignored; overflow
	// is remembered so end-of-data can refuse the commit
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			wr_buf <= '0;
			wr_cnt <= '0;
			wr_started <= 1'b0;
			wr_pos <= 1'b0;
		end else if (opening) begin
			wr_cnt <= '0;
			wr_started <= 1'b0;
		end else if (wr_take && (!wr_started || pos != wr_pos)) begin
			wr_started <= 1'b1;
			wr_pos <= pos;
			for (int i = 0; i < REG_BYTES; i++) begin
				if (wr_cnt == PW'(i))
					wr_buf[8*i +: 8] <= rx[orw_pkg::SUB_LSB +: 8]; // [RULE14]
			end
			if (wr_cnt != OVER)
				wr_cnt <= PW'(wr_cnt + 1'b1);                    // [RULE18]
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int r = 0; r < orw_pkg::REG_COUNT; r++)
				store[r] <= '0;
			REG_WR <= 1'b0;
			REG_WR_IDX <= 4'h0;
			REG_WR_DATA <= '0;
		end else begin
			REG_WR <= commit;
			if (commit) begin
				store[reg_idx] <= wr_buf;                         // [RULE17]
				REG_WR_IDX <= reg_idx;
				REG_WR_DATA <= wr_buf;
			end
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			LATCH_CLR <= 1'b0;
		else
			LATCH_CLR <= confirm && is_rtn;                       // [RULE22]
	end

	always_comb begin
		reply = rx;                                             // [RULE3] [RULE12]
		if (held && next_mode == orw_pkg::M_UTC && !is_rtn) begin
			reply = orw_pkg::op_frame(orw_pkg::OP_UTC, OWN_ADDR, 1'b0); // [RULE20]
		end else if (held && next_mode == orw_pkg::M_READ && is_op &&
			cmd == orw_pkg::OP_NEXT) begin
			if (next_ptr < NBYTES)
				reply = orw_pkg::data_frame(rd_byte, pos);       // [RULE5] [RULE6]
			else
				reply = orw_pkg::op_frame(orw_pkg::OP_EOD, 4'h0, pos); // [RULE9]
		end
	end

	// Every frame gets its answer in the next cycle
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			LNK.up_valid <= 1'b0;
			LNK.up_frame <= '0;
		end else begin
			LNK.up_valid <= LNK.dn_valid;
			if (LNK.dn_valid)
				LNK.up_frame <= reply;
		end
	end
endmodule

// [rtl/orw_pkg.sv]
// Shared constants, types and frame builders for the register channel
package orw_pkg;
	localparam int FRM_W = 16;
	typedef logic [FRM_W-1:0] orw_frame_t;

	// Frame layout: [15:12] command, [11:8] register index or address,
	// [15:8] data byte in a data frame, bit 4 byte position, bit 3 type
	localparam int TYPE_BIT = 3;
	localparam int POS_BIT  = 4;
	localparam int CMD_LSB  = 12;
	localparam int SUB_LSB  = 8;
	localparam logic TYPE_DATA = 1'b0;
	localparam logic TYPE_OP   = 1'b1;
	localparam logic POS_ODD   = 1'b1;

	localparam int REG_COUNT = 16;
	localparam logic [1:0] CONFIRM_CNT = 2'h3;

	localparam logic [3:0] OP_READ  = 4'h1;
	localparam logic [3:0] OP_WRITE = 4'h2;
	localparam logic [3:0] OP_NEXT  = 4'h3;
	localparam logic [3:0] OP_EOD   = 4'h4;
	localparam logic [3:0] OP_HOLD  = 4'h5;
	localparam logic [3:0] OP_RTN   = 4'h6;
	localparam logic [3:0] OP_UTC   = 4'h7;

	typedef enum logic [1:0] {M_NORMAL, M_READ, M_WRITE, M_UTC} orw_mode_e;
	typedef enum logic [2:0] {P_IDLE, P_CMD, P_BYTE, P_EOD, P_END} orw_phase_e;

	// Controller registers on APB
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_WDATA  = 8'h04;
	localparam logic [7:0] A_RDATA  = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0C;
	localparam int CTRL_START = 0;
	localparam int CTRL_DIR   = 1;
	localparam int CTRL_RTN   = 2;
	localparam int CTRL_IDX   = 4;
	localparam int CTRL_NB    = 8;
	localparam int ST_BUSY    = 0;
	localparam int ST_DONE    = 1;
	localparam int ST_UTC     = 2;
	localparam int ST_EOD     = 3;
	localparam int ST_NB      = 4;

	function automatic orw_frame_t op_frame(logic [3:0] cmd, logic [3:0] sub,
		logic pos);
		orw_frame_t f;
		f = '0;
		f[CMD_LSB +: 4] = cmd;
		f[SUB_LSB +: 4] = sub;
		f[TYPE_BIT] = TYPE_OP;
		f[POS_BIT] = pos;
		return f;
	endfunction

	function automatic orw_frame_t data_frame(logic [7:0] b, logic pos);
		orw_frame_t f;
		f = '0;
		f[SUB_LSB +: 8] = b;
		f[TYPE_BIT] = TYPE_DATA;
		f[POS_BIT] = pos;
		return f;
	endfunction
endpackage

// [rtl/orw_link_if.sv]
// Operations channel link between line-side master and remote unit
`timescale 1ns/1ps
interface orw_link_if;
	logic                 dn_valid;
	orw_pkg::orw_frame_t  dn_frame;
	logic                 up_valid;
	orw_pkg::orw_frame_t  up_frame;

	modport master (output dn_valid, output dn_frame,
		input up_valid, input up_frame);
	modport remote (input dn_valid, input dn_frame,
		output up_valid, output up_frame);
endinterface

// [rtl/orw_line_master.sv]
// Line-side master end: APB-controlled register read and write engine
`timescale 1ns/1ps
module orw_line_master (
	input  wire logic          SYS_CLK,
	input  wire logic          SYS_RST,
	orw_link_if.master         LNK,
	input  wire logic          PSEL,
	input  wire logic          PENABLE,
	input  wire logic          PWRITE,
	input  wire logic [7:0]    PADDR,
	input  wire logic [31:0]   PWDATA,
	output logic [31:0]        PRDATA,
	output logic               PREADY,
	output logic               PSLVERR
);
	orw_pkg::orw_phase_e  phase;
	orw_pkg::orw_frame_t  txf;
	orw_pkg::orw_frame_t  rx;
	orw_pkg::orw_frame_t  prev_rx;
	logic [1:0]           mcnt;
	logic [1:0]           ncnt;
	logic                 got3;
	logic                 rx_utc;
	logic                 waiting;
	logic                 dir_wr;
	logic                 end_rtn;
	logic [3:0]           idx;
	logic [2:0]           nbytes;
	logic [2:0]           k;
	logic                 pos;
	logic [31:0]          wdata;
	logic [31:0]          rbuf;
	logic                 done;
	logic                 unable_to_comply;
	logic                 eod;
	logic                 acc;
	logic                 wr_acc;
	logic                 mapped;
	logic [31:0]          rd_val;
	logic                 last_byte;

	assign acc    = PSEL && PENABLE && !PREADY;
	assign wr_acc = PSEL && PENABLE && PREADY && PWRITE;
	assign mapped = PADDR == orw_pkg::A_CTRL || PADDR == orw_pkg::A_WDATA ||
		PADDR == orw_pkg::A_RDATA || PADDR == orw_pkg::A_STATUS;

	always_comb begin
		rd_val = 32'h0000_0000;
		if (PADDR == orw_pkg::A_WDATA)
			rd_val = wdata;
		else if (PADDR == orw_pkg::A_RDATA)
			rd_val = rbuf;
		else if (PADDR == orw_pkg::A_STATUS) begin
			rd_val[orw_pkg::ST_BUSY] = phase != orw_pkg::P_IDLE;
			rd_val[orw_pkg::ST_DONE] = done;
			rd_val[orw_pkg::ST_UTC] = unable_to_comply;
			rd_val[orw_pkg::ST_EOD] = eod;
			rd_val[orw_pkg::ST_NB +: 3] = k;
		end
	end

	// One wait state: pready rises on the second access cycle
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= acc;
			PSLVERR <= acc && !mapped;
			if (acc && !PWRITE)
				PRDATA <= rd_val;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST)
			wdata <= 32'h0000_0000;
		else if (wr_acc && PADDR == orw_pkg::A_WDATA)
			wdata <= PWDATA;
	end

	assign pos = ~k[0];                                        // [RULE15]
	assign last_byte = 3'(k + 3'h1) == nbytes;

	always_comb begin
		txf = '0;
		unique case (phase)
			orw_pkg::P_IDLE: txf = '0;
			orw_pkg::P_CMD: txf = orw_pkg::op_frame(dir_wr ? orw_pkg::OP_WRITE :
				orw_pkg::OP_READ, idx, 1'b0);
			orw_pkg::P_BYTE: txf = dir_wr ?
				orw_pkg::data_frame(wdata[8*k +: 8], pos) :     // [RULE13]
				orw_pkg::op_frame(orw_pkg::OP_NEXT, 4'h0, pos); // [RULE4] [RULE10]
			orw_pkg::P_EOD: txf = orw_pkg::op_frame(orw_pkg::OP_EOD, 4'h0, 1'b0);
			orw_pkg::P_END: txf = orw_pkg::op_frame(end_rtn ? orw_pkg::OP_RTN :
				orw_pkg::OP_HOLD, 4'h0, 1'b0);
		endcase
	end

	assign rx = LNK.up_frame;
	assign ncnt = !((rx == prev_rx) && (mcnt != 2'h0)) ? 2'h1 :
		(mcnt == orw_pkg::CONFIRM_CNT) ? orw_pkg::CONFIRM_CNT :
		2'(mcnt + 2'h1);
	assign got3 = LNK.up_valid && ncnt == orw_pkg::CONFIRM_CNT;
	assign rx_utc = rx[orw_pkg::TYPE_BIT] &&
		rx[orw_pkg::CMD_LSB +: 4] == orw_pkg::OP_UTC;

	// Status flags are cleared only by a start, which is refused while
	// busy, so a hardware set can never meet a clear
	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			phase <= orw_pkg::P_IDLE;
			dir_wr <= 1'b0;
			end_rtn <= 1'b0;
			idx <= 4'h0;
			nbytes <= 3'h0;
			k <= 3'h0;
			rbuf <= 32'h0000_0000;
			done <= 1'b0;
			unable_to_comply <= 1'b0;
			eod <= 1'b0;
			waiting <= 1'b0;
			mcnt <= 2'h0;
			prev_rx <= '0;
			LNK.dn_valid <= 1'b0;
			LNK.dn_frame <= '0;
		end else begin
			LNK.dn_valid <= 1'b0;
			if (phase == orw_pkg::P_IDLE) begin
				if (wr_acc && PADDR == orw_pkg::A_CTRL &&
					PWDATA[orw_pkg::CTRL_START]) begin
					dir_wr <= PWDATA[orw_pkg::CTRL_DIR];
					end_rtn <= PWDATA[orw_pkg::CTRL_RTN];
					idx <= PWDATA[orw_pkg::CTRL_IDX +: 4];
					nbytes <= PWDATA[orw_pkg::CTRL_NB +: 3];
					k <= 3'h0;
					done <= 1'b0;
					unable_to_comply <= 1'b0;
					eod <= 1'b0;
					mcnt <= 2'h0;
					phase <= orw_pkg::P_CMD;
				end
			end else if (!waiting) begin
				LNK.dn_valid <= 1'b1;
				LNK.dn_frame <= txf;
				waiting <= 1'b1;
			end else if (LNK.up_valid) begin
				waiting <= 1'b0;
				prev_rx <= rx;
				mcnt <= ncnt;
				if (got3) begin
					if (rx_utc && phase != orw_pkg::P_END) begin
						unable_to_comply <= 1'b1;
						end_rtn <= 1'b1;
						mcnt <= 2'h0;
						phase <= orw_pkg::P_END;
					end else begin
						unique case (phase)
							orw_pkg::P_CMD: if (rx == txf) begin
								mcnt <= 2'h0;
								phase <= orw_pkg::P_BYTE;
							end
							orw_pkg::P_BYTE: begin
								if (dir_wr && rx == txf) begin
									mcnt <= 2'h0;
									k <= 3'(k + 3'h1);         // [RULE15]
									if (last_byte)
										phase <= orw_pkg::P_EOD; // [RULE16]
								end else if (!dir_wr &&
									rx[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_DATA &&
									rx[orw_pkg::POS_BIT] == pos) begin
									mcnt <= 2'h0;
									rbuf[8*k +: 8] <= rx[orw_pkg::SUB_LSB +: 8];
									k <= 3'(k + 3'h1);         // [RULE10]
									if (last_byte)
										phase <= orw_pkg::P_END;
								end else if (!dir_wr && rx[orw_pkg::TYPE_BIT] &&
									rx[orw_pkg::CMD_LSB +: 4] == orw_pkg::OP_EOD) begin
									eod <= 1'b1;               // [RULE10]
									mcnt <= 2'h0;
									phase <= orw_pkg::P_END;
								end
							end
							orw_pkg::P_EOD, orw_pkg::P_END: if (rx == txf) begin
								done <= 1'b1;
								mcnt <= 2'h0;
								phase <= orw_pkg::P_IDLE;
							end
							default: phase <= orw_pkg::P_IDLE;
						endcase
					end
				end
			end
		end
	end
endmodule

// [sim/orw_link_checker.sv]
// Link checker: reply kinds and reply timing on the operations channel
`timescale 1ns/1ps
module orw_link_checker #(
	parameter logic [3:0] OWN_ADDR = 4'h1 // Arbitrary unit address
) (
	input  wire logic                SYS_CLK,
	input  wire logic                SYS_RST,
	input  wire logic                dn_valid,
	input  wire orw_pkg::orw_frame_t dn_frame,
	input  wire logic                up_valid,
	input  wire orw_pkg::orw_frame_t up_frame,
	input  wire logic                REG_WR
);
	orw_pkg::orw_frame_t dn_last;
	orw_pkg::orw_frame_t up_last;
	logic [2:0]          dn_rep;
	logic [2:0]          up_rep;
	logic [2:0]          next_dn_rep;
	logic [2:0]          next_up_rep;
	logic [3:0]          up_cmd;
	logic [3:0]          dn_cmd;
	logic [3:0]          last_cmd;

	assign up_cmd = up_frame[orw_pkg::CMD_LSB +: 4];
	assign dn_cmd = dn_frame[orw_pkg::CMD_LSB +: 4];
	assign last_cmd = dn_last[orw_pkg::CMD_LSB +: 4];

	// Counts saturate at four: only first, second, third and later matter
	always_comb begin
		next_dn_rep = 3'h1;
		if (dn_frame == dn_last && dn_rep != 3'h0)
			next_dn_rep = (dn_rep == 3'h4) ? 3'h4 : dn_rep + 3'h1;
		next_up_rep = 3'h1;
		if (up_frame == up_last && up_rep != 3'h0)
			next_up_rep = (up_rep == 3'h4) ? 3'h4 : up_rep + 3'h1;
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			dn_rep <= 3'h0;
			dn_last <= '0;
		end else if (dn_valid) begin
			dn_rep <= next_dn_rep;
			dn_last <= dn_frame;
		end
	end

	always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			up_rep <= 3'h0;
			up_last <= '0;
		end else if (up_valid) begin
			up_rep <= next_up_rep;
			up_last <= up_frame;
		end
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (SYS_RST);

	sequence read_ok;
		up_valid && up_cmd == orw_pkg::OP_READ
			&& up_frame[orw_pkg::TYPE_BIT] && next_up_rep == 3'h3;
	endsequence

	sequence write_ok;
		up_valid && up_cmd == orw_pkg::OP_WRITE
			&& up_frame[orw_pkg::TYPE_BIT] && next_up_rep == 3'h3;
	endsequence

	answer_time_a: assert property (dn_valid |=> up_valid)
		else $error("no answer one cycle after a frame");
	no_extra_a: assert property (up_valid |-> $past(dn_valid))
		else $error("answer without a frame");
	early_echo_a: assert property (
		up_valid && dn_rep <= 3'h2 |-> up_frame == dn_last)
		else $error("first or second copy not echoed");
	data_reply_a: assert property (
		up_valid && up_frame[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_DATA
		&& up_frame != dn_last |-> last_cmd == orw_pkg::OP_NEXT
		&& dn_rep >= 3'h3 && up_frame[7:5] == 3'h0
		&& up_frame[2:0] == 3'h0
		&& up_frame[orw_pkg::POS_BIT] == dn_last[orw_pkg::POS_BIT])
		else $error("data frame not answering a confirmed request");
	// Type is tested first: a data byte may carry any command nibble
	eod_reply_a: assert property (
		up_valid && up_frame[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_OP
		&& up_cmd == orw_pkg::OP_EOD && up_frame != dn_last
		|-> last_cmd == orw_pkg::OP_NEXT && dn_rep >= 3'h3
		&& up_frame[orw_pkg::SUB_LSB +: 4] == 4'h0
		&& up_frame[orw_pkg::POS_BIT] == dn_last[orw_pkg::POS_BIT])
		else $error("end-of-data reply out of place");
	utc_reply_a: assert property (
		up_valid && up_frame[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_OP
		&& up_cmd == orw_pkg::OP_UTC && up_frame != dn_last
		|-> dn_rep >= 3'h3
		&& up_frame == orw_pkg::op_frame(orw_pkg::OP_UTC, OWN_ADDR, 1'b0))
		else $error("unable_to_comply reply malformed or early");
	repeat_same_a: assert property (
		up_valid && dn_rep == 3'h4 |-> up_frame == up_last)
		else $error("later copy changed the answer");
	commit_when_a: assert property (
		REG_WR |-> $past(dn_valid) && last_cmd == orw_pkg::OP_EOD
		&& dn_rep == 3'h3)
		else $error("commit without third end-of-data");
	read_next_a: assert property (read_ok |-> ##2 (dn_valid
		&& dn_cmd == orw_pkg::OP_NEXT
		&& dn_frame[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_OP
		&& dn_frame[orw_pkg::POS_BIT] == orw_pkg::POS_ODD))
		else $error("odd byte request missing after read opcode");
	write_first_a: assert property (write_ok |-> ##2 (dn_valid
		&& dn_frame[orw_pkg::TYPE_BIT] == orw_pkg::TYPE_DATA
		&& dn_frame[orw_pkg::POS_BIT] == orw_pkg::POS_ODD))
		else $error("odd data byte missing after write opcode");
endmodule

// [sim/ops_channel_register_rw_handler_bench.sv]
// Bench: both channel ends joined, driven from the master's APB side
`timescale 1ns/1ps
module ops_channel_register_rw_handler_bench;
	logic               sys_clk;
	logic               sys_rst;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [7:0]         paddr;
	logic [31:0]        pwdata;
	logic [31:0]        prdata;
	logic               pready;
	logic               pslverr;
	logic               reg_wr;
	logic [3:0]         reg_wr_idx;
	logic [15:0]        reg_wr_data;
	logic               latch_clr;
	orw_pkg::orw_mode_e mode;
	logic [31:0]        rd;
	logic               err;
	logic [31:0]        st;
	int                 fails = 0;
	int                 cmp_count = 0;
	int                 wr_seen = 0;
	int                 clr_seen = 0;

	orw_link_if lnk ();

	orw_remote #(.REG_BYTES(2), .OWN_ADDR(4'h1)) u_orw_remote (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LNK(lnk),
		.REG_WR(reg_wr), .REG_WR_IDX(reg_wr_idx),
		.REG_WR_DATA(reg_wr_data), .LATCH_CLR(latch_clr), .MODE(mode));

	orw_line_master u_orw_line_master (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .LNK(lnk),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr));

	orw_link_checker #(.OWN_ADDR(4'h1)) u_orw_link_checker (
		.SYS_CLK(sys_clk), .SYS_RST(sys_rst),
		.dn_valid(lnk.dn_valid), .dn_frame(lnk.dn_frame),
		.up_valid(lnk.up_valid), .up_frame(lnk.up_frame),
		.REG_WR(reg_wr));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (reg_wr === 1'b1)
			wr_seen <= wr_seen + 1;
		if (latch_clr === 1'b1)
			clr_seen <= clr_seen + 1;
	end

	task automatic wrap_up;
		$display("mismatches %0d of %0d comparisons", fails, cmp_count);
		if (fails == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the slave's wait is not assumed, only bounded
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			fails++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	// Start a transfer and poll status until the engine is idle
	task automatic run(input logic w, input logic rt, input logic [3:0] i,
		input logic [2:0] nb);
		logic [31:0] c;
		int n;
		c = 32'h0;
		c[orw_pkg::CTRL_START] = 1'b1;
		c[orw_pkg::CTRL_DIR] = w;
		c[orw_pkg::CTRL_RTN] = rt;
		c[orw_pkg::CTRL_IDX +: 4] = i;
		c[orw_pkg::CTRL_NB +: 3] = nb;
		apb(1'b1, orw_pkg::A_CTRL, c);
		n = 0;
		do begin
			apb(1'b0, orw_pkg::A_STATUS, 32'h0);
			n++;
		end while (rd[orw_pkg::ST_BUSY] !== 1'b0 && n < 300);
		st = rd;
		if (st[orw_pkg::ST_BUSY] !== 1'b0) begin
			fails++;
			wrap_up();
		end
		apb(1'b0, orw_pkg::A_RDATA, 32'h0);
	endtask

	initial begin
		sys_rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (5) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		chk(32'(mode), 32'(orw_pkg::M_NORMAL));
		chk(32'(reg_wr_data), 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(err), 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, orw_pkg::A_WDATA, 32'h0000A5C3);
		chk(32'(err), 32'h0);
		apb(1'b0, orw_pkg::A_WDATA, 32'h0);
		chk(rd, 32'h0000A5C3);
		run(1'b1, 1'b1, 4'h5, 3'h2);
		chk(32'(st[orw_pkg::ST_DONE]), 32'h1);
		chk(32'(wr_seen), 32'h1);
		chk(32'(reg_wr_idx), 32'h5);
		chk(32'(reg_wr_data), 32'h0000A5C3);
		chk(32'(mode), 32'(orw_pkg::M_NORMAL));
		run(1'b0, 1'b1, 4'h5, 3'h2);
		chk(rd & 32'h0000FFFF, 32'h0000A5C3);
		chk(32'(st[orw_pkg::ST_EOD]), 32'h0);
		chk(32'(clr_seen), 32'h1);
		run(1'b0, 1'b0, 4'h5, 3'h3);
		chk(rd & 32'h0000FFFF, 32'h0000A5C3);
		chk(32'(st[orw_pkg::ST_EOD]), 32'h1);
		chk(32'(st[orw_pkg::ST_NB +: 3]), 32'h2);
		chk(32'(clr_seen), 32'h1);
		chk(32'(mode), 32'(orw_pkg::M_NORMAL));
		apb(1'b1, orw_pkg::A_WDATA, 32'h0000005A);
		run(1'b1, 1'b1, 4'h5, 3'h1);
		chk(32'(st[orw_pkg::ST_UTC]), 32'h1);
		chk(32'(wr_seen), 32'h1);
		chk(32'(mode), 32'(orw_pkg::M_NORMAL));
		chk(32'(clr_seen), 32'h2);
		run(1'b0, 1'b1, 4'h5, 3'h2);
		chk(rd & 32'h0000FFFF, 32'h0000A5C3);
		apb(1'b1, orw_pkg::A_WDATA, 32'h00000F1E);
		run(1'b1, 1'b0, 4'hF, 3'h2);
		chk(32'(reg_wr_idx), 32'hF);
		chk(32'(reg_wr_data), 32'h00000F1E);
		wrap_up();
	end
endmodule
